// [hw/wff_filter_top.sv]
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Operation
// RULE_01 - address-type bit set restricts a filter to multicast frames, clear to unicast frames.
// RULE_02 - with chain set a filter's result is its match ANDed with the previous filter's match.
// RULE_03 - filter zero with chain set combines with the global unicast result from event control bit 9.
// RULE_04 - inverse bit makes a non-matching frame produce the wake event.
// RULE_05 - a filter only contributes while its enable bit is set.
// RULE_06 - the pattern offset is a byte index counted from the first destination address byte.
// RULE_07 - software programs each offset to at least twelve.
// RULE_08 - the final crc equal to the stored pattern crc is a match.
// RULE_09 - software precomputes the pattern crc from the pattern bytes and byte mask.
// RULE_10 - offset and crc storage is untouched by every reset.
// RULE_11 - command, offset and crc storage has no read path.
// RULE_12 - byte offset plus j enters the crc when mask bit j is set.
// RULE_13 - with config select set, eight load-port writes fill the filter block from the first mask word.
// RULE_14 - global unicast enable makes any address-passed unicast frame a wake frame.
// RULE_15 - a wake indication is raised when any enabled filter chain matches at frame end; the code also requires wake enable, event control bit 2.
module wff_filter_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire wff_pkg::wff_rx_t rxIn,
  output logic wakeEvent,
  output logic irq
);
  localparam int NF = wff_pkg::NUM_FILTERS;

  // frame stream comes from the receive logic on this clock
  logic [31:0] maskMem [NF];
  logic [7:0] offsMem [NF];
  logic [15:0] crcMem [NF];
  logic [15:0] crcValue [NF];

  logic [31:0] control_reg, control_next;
  logic [31:0] event_reg, event_next;
  logic [1:0] irqStat_reg, irqStat_next;
  logic [1:0] irqMask_reg, irqMask_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [2:0] loadCnt_reg, loadCnt_next;
  logic [7:0] byteIdx_reg, byteIdx_next;
  logic frameMcast_reg, frameMcast_next;
  logic frameUni_reg, frameUni_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wake_reg, wake_next;
  logic irq_reg, irq_next;
  logic evalPulse_reg, evalPulse_next;

  logic loadWr;
  logic [NF-1:0] rawMatch;
  logic [NF-1:0] chainMatch;
  logic [NF-1:0] fires;
  logic anyFire;
  logic frameEnd;
  wff_pkg::wff_cmd_t cmdF [NF];

  initial begin
    if (NF != 4) $error("filter block layout needs four filters");
  end

  assign loadWr = regWr && regAddr == wff_pkg::OFS_LOAD && control_reg[wff_pkg::BIT_CFG_SEL];

  // pattern storage: no reset, no read path
  always_ff @(posedge sys_clk) begin
    if (clkEn && loadWr) begin // RULE_13
      if (loadCnt_reg < wff_pkg::WORD_CMD) begin
        maskMem[loadCnt_reg[1:0]] <= {1'b0, regWdata[30:0]};
      end else if (loadCnt_reg == wff_pkg::WORD_OFS) begin
        for (int i = 0; i < NF; i++) begin
          offsMem[i] <= regWdata[i*wff_pkg::OFFSET_W +: wff_pkg::OFFSET_W]; // RULE_10
        end
      end else if (loadCnt_reg == wff_pkg::WORD_CRC01) begin
        crcMem[0] <= regWdata[15:0]; // RULE_10
        crcMem[1] <= regWdata[31:16];
      end else if (loadCnt_reg == wff_pkg::WORD_CRC23) begin
        crcMem[2] <= regWdata[15:0];
        crcMem[3] <= regWdata[31:16];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_lane
      wff_filter_lane u_lane (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .rx(rxIn),
        .byteIdx(rxIn.sof ? 8'h00 : byteIdx_reg),
        .byteMask(maskMem[g][30:0]),
        .patternOffset(offsMem[g]),
        .crcValue(crcValue[g])
      );
      assign cmdF[g] = wff_pkg::wff_cmd_t'(cmd_reg[g*wff_pkg::CMD_W +: wff_pkg::CMD_W]);
      assign rawMatch[g] = (crcValue[g] == crcMem[g]) && // RULE_08
        (cmdF[g].mcast ? frameMcast_reg : !frameMcast_reg); // RULE_01
    end
  endgenerate

  always_comb begin
    logic globalUni;
    globalUni = event_reg[wff_pkg::BIT_GLOBAL_UNI] && frameUni_reg; // RULE_14
    for (int i = 0; i < NF; i++) begin
      logic prev;
      logic own;
      prev = (i == 0) ? globalUni : chainMatch[(i == 0) ? 0 : i - 1]; // RULE_03
      own = cmdF[i].inverse ? !rawMatch[i] : rawMatch[i]; // RULE_04
      own = own && cmdF[i].enable; // RULE_05
      chainMatch[i] = cmdF[i].chain ? (own && prev) : own; // RULE_02
      fires[i] = chainMatch[i];
    end
    anyFire = (|fires) || globalUni; // RULE_15
  end

  assign frameEnd = evalPulse_reg;

  always_comb begin
    byteIdx_next = byteIdx_reg;
    frameMcast_next = frameMcast_reg;
    frameUni_next = frameUni_reg;
    evalPulse_next = 1'b0;
    if (rxIn.valid) begin
      byteIdx_next = (rxIn.sof ? 8'h00 : byteIdx_reg) + 8'h01;
      if (byteIdx_reg == 8'hFF && !rxIn.sof) begin
        byteIdx_next = 8'hFF;
      end
      if (rxIn.sof) begin
        frameMcast_next = rxIn.isMcast;
        frameUni_next = rxIn.uniPass && !rxIn.isMcast;
      end
      evalPulse_next = rxIn.eof;
    end
  end

  always_comb begin
    control_next = control_reg;
    event_next = event_reg;
    cmd_next = cmd_reg;
    loadCnt_next = loadCnt_reg;
    irqMask_next = irqMask_reg;
    irqStat_next = irqStat_reg;
    rdata_next = 32'h0000_0000;
    wake_next = 1'b0;
    if (regWr) begin
      unique case (regAddr)
        wff_pkg::OFS_CONTROL: begin
          control_next = regWdata & (32'h0000_0001 << wff_pkg::BIT_CFG_SEL);
          loadCnt_next = 3'h0;
        end
        wff_pkg::OFS_EVENT: begin
          if (control_reg[wff_pkg::BIT_CFG_SEL]) begin
            event_next = regWdata & ~(32'h0000_0001 << wff_pkg::BIT_WAKE_RCVD) & ~32'h0000_0100;
            event_next[wff_pkg::BIT_WAKE_RCVD] = event_reg[wff_pkg::BIT_WAKE_RCVD]
              && !regWdata[wff_pkg::BIT_WAKE_RCVD];
          end
        end
        wff_pkg::OFS_IRQ_STAT: irqStat_next = irqStat_reg & ~regWdata[1:0];
        wff_pkg::OFS_IRQ_MASK: irqMask_next = regWdata[1:0];
        wff_pkg::OFS_LOAD: begin
          if (loadWr) begin
            if (loadCnt_reg == wff_pkg::WORD_CMD) begin
              for (int i = 0; i < NF; i++) begin
                cmd_next[i*wff_pkg::CMD_W +: wff_pkg::CMD_W] =
                  regWdata[i*wff_pkg::CMD_STRIDE +: wff_pkg::CMD_W];
              end
            end
            loadCnt_next = loadCnt_reg + 3'h1; // RULE_13
          end
        end
        default: ;
      endcase
    end
    if (regRd) begin
      // load port and filter fields read as zero
      unique case (regAddr)
        wff_pkg::OFS_CONTROL: rdata_next = control_reg;
        wff_pkg::OFS_EVENT: rdata_next = event_reg;
        wff_pkg::OFS_IRQ_STAT: rdata_next = {30'h0, irqStat_reg};
        wff_pkg::OFS_IRQ_MASK: rdata_next = {30'h0, irqMask_reg};
        default: rdata_next = 32'h0000_0000; // RULE_11
      endcase
    end
    if (frameEnd) begin
      irqStat_next[wff_pkg::IRQ_FRAME] = 1'b1;
      if (anyFire && event_reg[wff_pkg::BIT_WAKE_EN]) begin
        wake_next = 1'b1; // RULE_15
        event_next[wff_pkg::BIT_WAKE_RCVD] = 1'b1;
        irqStat_next[wff_pkg::IRQ_WAKE] = 1'b1;
      end
    end
    // a set mask bit hides its status bit from the interrupt line
    irq_next = |(irqStat_next & ~irqMask_next);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      control_reg <= 32'h0000_0000;
      event_reg <= 32'h0000_0000;
      cmd_reg <= 16'h0000;
      loadCnt_reg <= 3'h0;
      irqStat_reg <= wff_pkg::IRQ_RESET;
      irqMask_reg <= wff_pkg::IRQ_RESET;
      byteIdx_reg <= 8'h00;
      frameMcast_reg <= 1'b0;
      frameUni_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
      evalPulse_reg <= 1'b0;
    end else if (clkEn) begin
      control_reg <= control_next;
      event_reg <= event_next;
      cmd_reg <= cmd_next;
      loadCnt_reg <= loadCnt_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      byteIdx_reg <= byteIdx_next;
      frameMcast_reg <= frameMcast_next;
      frameUni_reg <= frameUni_next;
      rdata_reg <= rdata_next;
      wake_reg <= wake_next;
      irq_reg <= irq_next;
      evalPulse_reg <= evalPulse_next;
    end
  end

  assign regRdata = rdata_reg;
  assign wakeEvent = wake_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wake_needs_end_a: assert property (wakeEvent |-> $past(frameEnd) && $past(event_reg[wff_pkg::BIT_WAKE_EN])) // RULE_15
    else $error("wake without frame end");
  wake_sets_stat_a: assert property (wakeEvent |-> event_reg[wff_pkg::BIT_WAKE_RCVD] && irqStat_reg[0]) // RULE_15
    else $error("wake did not set status");
  disabled_quiet_a: assert property (cmd_reg == 16'h0 && !event_reg[wff_pkg::BIT_GLOBAL_UNI] |-> !anyFire) // RULE_05
    else $error("disabled filters fired");
  load_count_a: assert property (loadWr && clkEn && !rxIn.valid |=> loadCnt_reg == $past(loadCnt_reg) + 3'h1) // RULE_13
    else $error("load pointer not advanced");
  no_readback_a: assert property (regRd && regAddr == wff_pkg::OFS_LOAD && clkEn |=> regRdata == 32'h0) // RULE_11
    else $error("filter storage readable");
  inverse_a: assert property (cmdF[0].enable && cmdF[0].inverse && !cmdF[0].chain |-> chainMatch[0] == !rawMatch[0]) // RULE_04
    else $error("inverse wrong");
  chain_a: assert property (cmdF[1].chain && !chainMatch[0] |-> !chainMatch[1]) // RULE_02
    else $error("chain not anded");
  mcast_a: assert property (cmdF[2].mcast && !frameMcast_reg |-> !rawMatch[2]) // RULE_01
    else $error("address type ignored");
  irq_level_a: assert property (irq |-> $past(|(irqStat_next & ~irqMask_next)))
    else $error("irq without status");
  cover_wake_c: cover property (wakeEvent);
  cover_chain_c: cover property (frameEnd && cmdF[1].chain && chainMatch[1]);
  cover_load_c: cover property (loadWr && loadCnt_reg == wff_pkg::WORD_CRC23);
endmodule // wff_filter_top

// [hw/wff_pkg.sv]
package wff_pkg;
  localparam int NUM_FILTERS = 4;
  localparam int MASK_W = 31;
  localparam int CRC_W = 16;
  localparam int LOAD_WORDS = 8;
  localparam int LOAD_CNT_W = 3;
  localparam int ADDR_W = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h08;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // control register fields
  localparam int BIT_CFG_SEL = 26;
  // event control fields
  localparam int BIT_GLOBAL_UNI = 9;
  localparam int BIT_WAKE_RCVD = 6;
  localparam int BIT_WAKE_EN = 2;
  // command bits
  localparam int CMD_ENABLE = 0;
  localparam int CMD_INVERSE = 1;
  localparam int CMD_CHAIN = 2;
  localparam int CMD_MCAST = 3;
  localparam int CMD_W = 4;
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam int CMD_STRIDE = 8;
  localparam int OFFSET_W = 8;
  localparam int MIN_OFFSET = 12;
  // load word indices
  localparam logic [2:0] WORD_CMD = 3'h4;
  localparam logic [2:0] WORD_OFS = 3'h5;
  localparam logic [2:0] WORD_CRC01 = 3'h6;
  localparam logic [2:0] WORD_CRC23 = 3'h7;
  // crc machine
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_FRAME = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic sof;
    logic eof;
    logic isMcast;
    logic uniPass;
  } wff_rx_t;

  typedef struct packed {
    logic mcast;
    logic chain;
    logic inverse;
    logic enable;
  } wff_cmd_t;
endpackage

// [hw/wff_crc16.sv]
`timescale 1ns/1ns
module wff_crc16 #(
  parameter logic [15:0] POLY = wff_pkg::CRC_POLY
) (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);
  always_comb begin
    logic [15:0] c;
    c = crcIn;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ dataIn[i]) begin
        c = {c[14:0], 1'b0} ^ POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crcOut = c;
  end
endmodule // wff_crc16

// [hw/wff_filter_lane.sv]
`timescale 1ns/1ns
module wff_filter_lane (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire wff_pkg::wff_rx_t rx,
  input wire logic [7:0] byteIdx,
  input wire logic [30:0] byteMask,
  input wire logic [7:0] patternOffset,
  output logic [15:0] crcValue
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [15:0] crcStep;
  logic [15:0] crcBase;
  logic [8:0] rel;
  logic take;

  assign crcBase = rx.sof ? wff_pkg::CRC_INIT : crc_reg;

  wff_crc16 u_crc (
    .crcIn(crcBase),
    .dataIn(rx.data),
    .crcOut(crcStep)
  );

  always_comb begin
    rel = {1'b0, byteIdx} - {1'b0, patternOffset};
    // byte offset+j is taken when mask bit j is set
    take = (byteIdx >= patternOffset) && (rel < 9'(wff_pkg::MASK_W)) && byteMask[rel[4:0]]; // RULE_06 RULE_12
    crc_next = crc_reg;
    if (rx.valid) begin
      crc_next = take ? crcStep : crcBase;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      crc_reg <= wff_pkg::CRC_INIT;
    end else if (clkEn) begin
      crc_reg <= crc_next;
    end
  end

  assign crcValue = crc_reg;
endmodule // wff_filter_lane

// [dv/wff_frame_src.sv]
`timescale 1ns/1ns
module wff_frame_src (
  input wire logic sys_clk,
  output wff_pkg::wff_rx_t rx
);
  initial begin
    rx = '0;
  end
  // one byte per cycle, sof on the first destination byte
  task automatic send(input int len, input logic [7:0] base, input logic mc, input logic up);
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      rx <= '{valid: 1'h1, data: base + 8'(i * 7), sof: (i == 0), eof: (i == len - 1), isMcast: mc, uniPass: up};
    end
    @(posedge sys_clk);
    // idle line shows the inverse of the last byte
    rx <= '{valid: 1'h0, data: ~(base + 8'(len * 7 - 7)), sof: 1'h0, eof: 1'h0, isMcast: 1'h0, uniPass: 1'h0};
  endtask
endmodule // wff_frame_src

// [dv/wff_filter_top_tb.sv]
`timescale 1ns/1ns
module wff_filter_top_tb;
  localparam logic [7:0] BASE = 8'h3C;
  localparam int FLEN = 64;
  logic sys_clk;
  logic resetn;
  logic clkEn;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  wff_pkg::wff_rx_t rxIn;
  logic wakeEvent;
  logic irq;
  int errors;
  int n_checks;
  logic [31:0] cfg [8];

  wff_filter_top uut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIn(rxIn),
    .wakeEvent(wakeEvent), .irq(irq));
  wff_frame_src src (.sys_clk(sys_clk), .rx(rxIn));

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] pat_crc(input logic [7:0] ofs, input logic [30:0] mask);
    logic [15:0] c;
    logic [7:0] d;
    c = wff_pkg::CRC_INIT;
    for (int j = 0; j < 31; j++) begin
      if (mask[j] && int'(ofs) + j < FLEN) begin
        d = BASE + 8'(7 * (int'(ofs) + j));
        for (int b = 7; b >= 0; b--) begin
          c = {c[14:0], 1'h0} ^ ((c[15] ^ d[b]) ? wff_pkg::CRC_POLY : 16'h0000);
        end
      end
    end
    return c;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    check(w, regRdata & m, e);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    resetn <= 1'h0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
  endtask

  // offsets kept at twelve or more, crc worked out beforehand
  task automatic set_f(input int i, input logic [3:0] cmd, input logic [7:0] ofs, input logic [30:0] m,
    input logic good);
    cfg[i] = {1'h0, m};
    cfg[4][8*i+:4] = cmd;
    cfg[5][8*i+:8] = ofs;
    cfg[6+i/2][16*(i%2)+:16] = good ? pat_crc(ofs, m) : ~pat_crc(ofs, m);
  endtask

  task automatic load(input int n, input logic [31:0] ev);
    wr(wff_pkg::OFS_CONTROL, 32'h0400_0000);
    for (int k = 0; k < n; k++) wr(wff_pkg::OFS_LOAD, cfg[k]);
    wr(wff_pkg::OFS_EVENT, ev);
  endtask

  task automatic one(input int i, input logic [3:0] cmd, input logic good, input logic [31:0] ev);
    for (int k = 0; k < 4; k++) set_f(k, 4'h0, 8'h0C, 31'h0000_0001, 1'h0);
    set_f(i, cmd, 8'(12 + 3 * i), 31'h4000_0005, good);
    load(8, ev);
  endtask

  task automatic frame(input logic mc, input logic up, input logic exp, input string w);
    logic seen;
    src.send(FLEN, BASE, mc, up);
    seen = 1'h0;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      seen = seen | wakeEvent;
    end
    check(w, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic t_reset();
    check("idle read data", regRdata, 32'h0000_0000);
    check("idle outputs", {30'h0, wakeEvent, irq}, 32'h0000_0000);
    rd_chk(wff_pkg::OFS_LOAD, 32'hFFFF_FFFF, 32'h0, "load port read");
    rd_chk(8'hFC, 32'hFFFF_FFFF, 32'h0, "unmapped read");
  endtask

  task automatic t_match();
    for (int i = 0; i < 4; i++) begin
      one(i, 4'h1, 1'h1, 32'h0000_0004);
      frame(1'h0, 1'h1, 1'h1, "masked crc match");
      one(i, 4'h1, 1'h0, 32'h0000_0004);
      frame(1'h0, 1'h1, 1'h0, "crc mismatch");
      one(i, 4'h0, 1'h1, 32'h0000_0004);
      frame(1'h0, 1'h1, 1'h0, "disabled filter");
    end
  endtask

  task automatic t_addr_inv();
    one(1, 4'h9, 1'h1, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h0, "mcast filter unicast frame");
    frame(1'h1, 1'h0, 1'h1, "mcast filter mcast frame");
    one(1, 4'h1, 1'h1, 32'h0000_0004);
    frame(1'h1, 1'h0, 1'h0, "ucast filter mcast frame");
    one(2, 4'h3, 1'h0, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h1, "inverse no match");
    one(2, 4'h3, 1'h1, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h0, "inverse match");
  endtask

  task automatic t_chain();
    one(1, 4'h5, 1'h1, 32'h0000_0004);
    set_f(0, 4'h1, 8'h0C, 31'h0000_0003, 1'h0);
    load(8, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h0, "chain previous fails");
    one(0, 4'h5, 1'h1, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h0, "chain filter0 global off");
    one(0, 4'h0, 1'h0, 32'h0000_0204);
    frame(1'h0, 1'h1, 1'h1, "global unicast");
    frame(1'h1, 1'h0, 1'h0, "global unicast mcast frame");
  endtask

  task automatic t_gate_irq();
    one(3, 4'h1, 1'h1, 32'h0000_0004);
    wr(wff_pkg::OFS_CONTROL, 32'h0);
    for (int k = 0; k < 8; k++) wr(wff_pkg::OFS_LOAD, 32'h0);
    wr(wff_pkg::OFS_EVENT, 32'h0);
    wr(wff_pkg::OFS_IRQ_STAT, 32'h0000_0003);
    frame(1'h0, 1'h1, 1'h1, "load gated by select");
    rd_chk(wff_pkg::OFS_IRQ_STAT, 32'h0000_0003, 32'h0000_0003, "irq status");
    rd_chk(wff_pkg::OFS_EVENT, 32'h0000_0040, 32'h0000_0040, "wake received");
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(wff_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    #1;
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(wff_pkg::OFS_IRQ_MASK, 32'h0);
    #1;
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(wff_pkg::OFS_IRQ_STAT, 32'h0000_0003);
    #1;
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk(wff_pkg::OFS_IRQ_STAT, 32'h0000_0003, 32'h0, "irq status cleared");
  endtask

  task automatic t_retain();
    one(2, 4'h1, 1'h1, 32'h0000_0004);
    do_reset();
    frame(1'h0, 1'h1, 1'h0, "commands cleared by reset");
    load(5, 32'h0000_0004);
    frame(1'h0, 1'h1, 1'h1, "offset and crc kept");
  endtask

  initial begin
    {regAddr, regWdata, regWr, regRd} = '0;
    errors = 0;
    n_checks = 0;
    clkEn = 1'h1;
    resetn = 1'h0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    t_reset();
    t_match();
    t_addr_inv();
    t_chain();
    t_gate_irq();
    t_retain();
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
endmodule // wff_filter_top_tb
